// [logic/dacfe_consts.svh]
// Purpose: Constants for the dual converter capture front end.
// Assumes: mclk is the word-rate clock, one eighth of the sampling clock.
// Notes: Included by the package and by the top module.
// Behaviour
// - Deliver eight consecutive samples per 64-bit word at one eighth sample rate.
// - Handle two independent channels of 8-bit samples up to 1 GSPS.
// - Two external trigger inputs; a rising edge on either trigger starts acquisition.
// - A software trigger from the control port starts acquisition, with some latency.
// - Logic is loaded at power-up over control port three, shared with microcontroller.
// - After loading, port three writes control registers; only port three controls.
// - Only one converter clock input is used; external clocks are ignored.
// - Captured words can be forwarded to eight serial links, up to 1 GB/s.
// - Either kind of trigger activates capture of arriving samples.
`ifndef DACFE_CONSTS_SVH
`define DACFE_CONSTS_SVH
`define DACFE_SAMPLE_W     8
`define DACFE_LANES        8
`define DACFE_WORD_W       64
`define DACFE_LINKS        8
`define DACFE_CHANNELS     2
`define DACFE_CLK_HZ       10000000
`define DACFE_TRIG_MIN_NS  1000
`define DACFE_TRIG_CYC     ((`DACFE_TRIG_MIN_NS * (`DACFE_CLK_HZ / 1000000) + 999) / 1000)
`define DACFE_CMD_TRIGGER  8'h01
`define DACFE_CMD_STOP     8'h02
`endif

// [logic/dacfe_pkg.sv]
// Purpose: Types for the dual converter capture front end.
// Assumes: Constants header is on the include path.
// Notes: None.
`include "dacfe_consts.svh"
package dacfe_pkg;
	typedef logic [`DACFE_WORD_W-1:0] dacfe_word_t;
	typedef struct packed {
		logic        valid;
		dacfe_word_t in_phase_converter;
		dacfe_word_t quadrature_converter;
	} dacfe_out_s;
	typedef enum logic [0:0] {
		DACFE_IDLE    = 1'b0,
		DACFE_CAPTURE = 1'b1
	} dacfe_state_e;
	typedef struct packed {
		dacfe_state_e state;
		logic [1:0]   trig_prev;
		dacfe_out_s   out;
	} dacfe_st_s;
endpackage : dacfe_pkg

// [logic/dacfe_top.sv]
// Purpose: Capture front end packing two converter streams into 64-bit words.
// Assumes: Converter set for 1:8 demux; sample lanes arrive word-aligned on mclk.
// Notes: Control port loading and link protocols live outside this block.
`timescale 1ns/1ps
`include "dacfe_consts.svh"
module dacfe_top #(
	parameter int LANES = `DACFE_LANES,
	parameter int SW    = `DACFE_SAMPLE_W
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	// Converter sample lanes, lane 0 earliest
	input  wire logic [LANES*SW-1:0]     in_phase_converter,
	input  wire logic [LANES*SW-1:0]     quadrature_converter,
	// Triggers
	input  wire logic [1:0]              ext_trigger,
	input  wire logic                    cmd_valid,
	input  wire logic [7:0]              cmd_code,
	// Output words toward the serial links
	output dacfe_pkg::dacfe_out_s        link_out,
	output logic                         capture_active
);
	// Reset copy and registered state.
	logic [1:0]           rst_sync_r;
	logic                 rst_n_int;
	dacfe_pkg::dacfe_st_s st_r;
	dacfe_pkg::dacfe_st_s st_nxt;
	// Decoded starts and stops, and the lane-mapped words.
	logic [1:0]           ext_rise;
	logic                 sw_trig;
	logic                 sw_stop;
	logic                 trig_hit;
	logic [LANES*SW-1:0]  i_packed;
	logic [LANES*SW-1:0]  q_packed;

	// A command counts only when the port flags it present; other codes are dropped.
	function automatic logic is_cmd(
		input logic       valid,
		input logic [7:0] code,
		input logic [7:0] want
	);
		return valid && (code == want);
	endfunction : is_cmd

	function automatic logic [1:0] rising(
		input logic [1:0] cur,
		input logic [1:0] prev
	);
		return cur & ~prev;
	endfunction : rising

	// Everything runs on the one converter-derived clock; other clock inputs stay unused.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n_int = rst_sync_r[1];

	// The port is shared with the loader, so only flagged commands after loading arrive here.
	assign sw_trig  = is_cmd(cmd_valid, cmd_code, `DACFE_CMD_TRIGGER);
	assign sw_stop  = is_cmd(cmd_valid, cmd_code, `DACFE_CMD_STOP);
	// The history starts low, so a level already high at reset release reads as an edge.
	assign ext_rise = rising(ext_trigger, st_r.trig_prev);
	assign trig_hit = (|ext_rise) || sw_trig;

	// Lane k is sample k of the word, so the earliest sample sits in the low byte.
	for (genvar k = 0; k < LANES; k++)
	begin : g_lane
		assign i_packed[k*SW +: SW] = in_phase_converter[k*SW +: SW];
		assign q_packed[k*SW +: SW] = quadrature_converter[k*SW +: SW];
		lane_order_a: assert property (@(posedge mclk) disable iff (!rst_n_int)
			capture_active |=> link_out.in_phase_converter[k*SW +: SW]
			== $past(in_phase_converter[k*SW +: SW]))
			else $error("In-phase lane out of place in word.");
		q_lane_a: assert property (@(posedge mclk) disable iff (!rst_n_int)
			capture_active |=> link_out.quadrature_converter[k*SW +: SW]
			== $past(quadrature_converter[k*SW +: SW]))
			else $error("Quadrature lane out of place in word.");
	end

	always_comb
	begin
		st_nxt           = st_r;
		st_nxt.trig_prev = ext_trigger;
		st_nxt.out.valid = 1'b0;
		unique case (st_r.state)
			dacfe_pkg::DACFE_IDLE:
			begin
				if (trig_hit)
					st_nxt.state = dacfe_pkg::DACFE_CAPTURE;
			end
			dacfe_pkg::DACFE_CAPTURE:
			begin
				// One word of eight samples per channel each cycle, at one eighth rate.
				st_nxt.out.valid                = 1'b1;
				st_nxt.out.in_phase_converter   = dacfe_pkg::dacfe_word_t'(i_packed);
				st_nxt.out.quadrature_converter = dacfe_pkg::dacfe_word_t'(q_packed);
				// Triggers are ignored while capturing; only a stop ends it.
				if (sw_stop)
					st_nxt.state = dacfe_pkg::DACFE_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n_int)
	begin
		if (!rst_n_int)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign link_out = st_r.out;
	assign capture_active = (st_r.state == dacfe_pkg::DACFE_CAPTURE);

	// Steps of a capture: a start, its first word, and the last word after a stop.
	sequence trig_seq;
		sw_trig && st_r.state == dacfe_pkg::DACFE_IDLE;
	endsequence
	sequence ext_seq;
		(|ext_rise) && st_r.state == dacfe_pkg::DACFE_IDLE;
	endsequence
	sequence word_seq;
		##1 capture_active ##1 link_out.valid;
	endsequence
	sequence stop_seq;
		capture_active && sw_stop;
	endsequence
	sequence tail_seq;
		##1 (!capture_active && link_out.valid) ##1 !link_out.valid;
	endsequence

	property sw_start_p;
		@(posedge mclk) disable iff (!rst_n_int)
		trig_seq |-> word_seq;
	endproperty
	sw_trig_start_a: assert property (sw_start_p)
		else $error("Software trigger did not start capture.");

	property ext_start_p;
		@(posedge mclk) disable iff (!rst_n_int)
		ext_seq |-> word_seq;
	endproperty
	ext_first_word_a: assert property (ext_start_p)
		else $error("External trigger gave no first word.");

	property ext_edge_p;
		@(posedge mclk) disable iff (!rst_n_int)
		(st_r.state == dacfe_pkg::DACFE_IDLE && |(ext_trigger & ~st_r.trig_prev))
		|=> capture_active;
	endproperty
	ext_trig_start_a: assert property (ext_edge_p)
		else $error("External trigger did not start capture.");

	property idle_quiet_p;
		@(posedge mclk) disable iff (!rst_n_int)
		!capture_active |=> !link_out.valid;
	endproperty
	idle_no_valid_a: assert property (idle_quiet_p)
		else $error("Valid while idle.");

	property idle_hold_p;
		@(posedge mclk) disable iff (!rst_n_int)
		(!capture_active && !trig_hit) |=> !capture_active;
	endproperty
	idle_hold_a: assert property (idle_hold_p)
		else $error("Capture began without a trigger.");

	property busy_hold_p;
		@(posedge mclk) disable iff (!rst_n_int)
		(capture_active && !sw_stop) |=> capture_active;
	endproperty
	busy_hold_a: assert property (busy_hold_p)
		else $error("Capture ended without a stop.");

	property reset_quiet_p;
		@(posedge mclk)
		!rst_n_int |-> (!capture_active && !link_out.valid);
	endproperty
	reset_quiet_a: assert property (reset_quiet_p)
		else $error("Outputs active during reset.");

	property word_data_p;
		@(posedge mclk) disable iff (!rst_n_int)
		capture_active |=> link_out.valid
		&& link_out.in_phase_converter == $past(in_phase_converter);
	endproperty
	word_data_a: assert property (word_data_p)
		else $error("In-phase word mismatch.");

	property q_data_p;
		@(posedge mclk) disable iff (!rst_n_int)
		capture_active |=> link_out.quadrature_converter == $past(quadrature_converter);
	endproperty
	q_data_a: assert property (q_data_p)
		else $error("Quadrature word mismatch.");

	property low_byte_p;
		@(posedge mclk) disable iff (!rst_n_int)
		capture_active |=> link_out.in_phase_converter[SW-1:0]
		== $past(in_phase_converter[SW-1:0]);
	endproperty
	low_byte_a: assert property (low_byte_p)
		else $error("Earliest sample not in low byte.");

	property stop_cmd_p;
		@(posedge mclk) disable iff (!rst_n_int)
		(capture_active && cmd_valid && cmd_code == `DACFE_CMD_STOP) |=> !capture_active;
	endproperty
	stop_cmd_a: assert property (stop_cmd_p)
		else $error("Stop command ignored.");

	property stop_tail_p;
		@(posedge mclk) disable iff (!rst_n_int)
		stop_seq |-> tail_seq;
	endproperty
	stop_tail_a: assert property (stop_tail_p)
		else $error("Last word after a stop missing or repeated.");

	property valid_one_p;
		@(posedge mclk) disable iff (!rst_n_int)
		link_out.valid |-> $past(capture_active);
	endproperty
	valid_one_a: assert property (valid_one_p)
		else $error("Valid without capture.");

	// Each trigger input on its own must be able to start a capture.
	for (genvar t = 0; t < $bits(ext_trigger); t++)
	begin : g_trig_chk
		ext_bit_start_a: assert property (@(posedge mclk) disable iff (!rst_n_int)
			(!capture_active && ext_trigger[t] && !$past(ext_trigger[t])) |=> capture_active)
			else $error("Trigger input did not start capture.");
	end
endmodule : dacfe_top

// [verif/dacfe_conv_model.sv]
// Purpose: Converter model, eight consecutive samples per channel per word.
// Assumes: Demux and clocking are set as the capture logic needs.
// Notes: Q is the inverse of I, so swapped channels show up.
`timescale 1ns/1ps
module dacfe_conv_model (
	// Sample of lane 0
	input  wire logic [7:0]  base,
	// Lanes, lane 0 earliest
	output logic      [63:0] i_lanes,
	output logic      [63:0] q_lanes
);
	always_comb
		for (int k = 0; k < 8; k++)
		begin
			i_lanes[8*k+:8] = base + 8'(k);
			q_lanes[8*k+:8] = ~(base + 8'(k));
		end
endmodule : dacfe_conv_model

// [verif/dual_adc_capture_front_end_test.sv]
// Purpose: Random and corner tests of the capture front end.
// Assumes: Triggers are taken on rising edges or the trigger command.
// Notes: Data seen after an edge is the lanes sampled at that edge.
`timescale 1ns/1ps
`include "dacfe_consts.svh"
module dual_adc_capture_front_end_test;
	logic                    mclk = 0, reset_n = 0, cmd_valid = 0, act = 0, capture_active;
	logic [1:0]              ext_trigger = 0;
	logic [7:0]              cmd_code = 0, base = 0;
	logic [63:0]             i_l, q_l;
	dacfe_pkg::dacfe_out_s   link_out;
	int                      miscompares = 0, checks = 0;
	always #50 mclk = ~mclk;
	dacfe_conv_model u_dacfe_conv_model (.base(base), .i_lanes(i_l), .q_lanes(q_l));
	dacfe_top u_dacfe_top (.mclk(mclk), .reset_n(reset_n), .in_phase_converter(i_l),
		.quadrature_converter(q_l), .ext_trigger(ext_trigger), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .link_out(link_out), .capture_active(capture_active));
	function automatic logic [63:0] lanes(input logic [7:0] b);
		for (int k = 0; k < 8; k++)
			lanes[8*k+:8] = b + 8'(k);
	endfunction : lanes
	task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic step(input logic [1:0] e, input logic [7:0] cc, input logic cv);
		logic go, stop, was;
		go = !act && ((|(e & ~ext_trigger)) || (cv && cc == `DACFE_CMD_TRIGGER));
		stop = act && cv && cc == `DACFE_CMD_STOP;
		was = act;
		ext_trigger = e;
		cmd_code = cc;
		cmd_valid = cv;
		base = 8'($urandom);
		@(posedge mclk);
		#1;
		act = go | (act & !stop);
		cmp("active", 64'(act), 64'(capture_active));
		cmp("valid", 64'(was), 64'(link_out.valid));
		if (was)
		begin
			cmp("i_word", lanes(base), link_out.in_phase_converter);
			cmp("q_word", ~lanes(base), link_out.quadrature_converter);
		end
	endtask : step
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		void'($urandom(32'hbff419a4));
		repeat (12) @(posedge mclk);
		#1 reset_n = 1;
		repeat (3) step(2'h0, 8'h00, 1'b0);
		step(2'h0, `DACFE_CMD_STOP, 1'b1);
		step(2'h0, 8'h55, 1'b1);
		for (int s = 0; s < 3; s++)
		begin
			if (s == 2)
				step(2'h0, `DACFE_CMD_TRIGGER, 1'b1);
			else
				repeat (`DACFE_TRIG_CYC) step(2'(1 << s), 8'h00, 1'b0);
			step(2'h0, `DACFE_CMD_TRIGGER, 1'b1);
			repeat (8 + $urandom_range(20)) step(2'($urandom), 8'($urandom), 1'($urandom));
			step(2'h0, `DACFE_CMD_STOP, 1'b1);
			repeat (2) step(2'h0, 8'h00, 1'b0);
		end
		give_verdict;
	end
endmodule : dual_adc_capture_front_end_test
